// File: verif/cpu_model.sv
// Purpose: behavioural cpu core facing the interrupt controller
// Assumes: controller steps are one-cycle levels on i_clk
// Notes: mask set by reset and set_mask, cleared by the i_cli pulse
`timescale 1ns/10ps
module cpu_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire irq_ctrl_pkg::step_t i_step,
    input wire logic i_cli,
    input wire logic i_brk,
    input wire logic i_rti,
    input wire logic i_wait,
    output irq_ctrl_pkg::cpu_in_t o_cpu
);
    import irq_ctrl_pkg::*;
    logic mask_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mask_q <= 1'b1;
        end else if (i_step.set_mask) begin
            mask_q <= 1'b1;
        end else if (i_cli) begin
            mask_q <= 1'b0;
        end
    end
    assign o_cpu = '{mask: mask_q, brk: i_brk, return_from_interrupt: i_rti, wait_mode: i_wait};
endmodule // cpu_model

// File: verif/test_irq_ctrl.sv
// Purpose: self-checking bench of the interrupt controller
// Assumes: 20 MHz clock, register port with one-cycle read latency
// Notes: cpu_model answers only the set_mask step and keeps the mask flag
`timescale 1ns/10ps
module test_irq_ctrl;
    import irq_ctrl_pkg::*;
    logic i_clk, i_rst, i_wr, i_rd, i_ext_pin, i_reset_pin;
    logic [7:0] i_addr, i_wdata, o_rdata;
    logic [11:0] i_events, o_prog_bank, rem;
    logic [15:0] o_vector;
    logic o_wake, o_irq_pending, cli, brk, return_from_interrupt, wt;
    cpu_in_t cpu;
    bank_in_t i_bank;
    step_t o_step;
    int err_total, comparisons, n;
    localparam logic [15:0] EXP_VEC [0:10] = '{16'h7FE8, 16'h7FE6,
        16'h7FE4, 16'h7FE2, 16'h7FF8, 16'h7FF6, 16'h7FF4, 16'h7FF2,
        16'h7FF0, 16'h7FEE, 16'h7FEC};

    irq_ctrl dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_ext_pin(i_ext_pin), .i_reset_pin(i_reset_pin),
        .i_events(i_events), .i_cpu(cpu), .i_bank(i_bank), .o_step(o_step),
        .o_vector(o_vector), .o_prog_bank(o_prog_bank), .o_wake(o_wake),
        .o_irq_pending(o_irq_pending));
    cpu_model cpu_m (.i_clk(i_clk), .i_rst(i_rst), .i_step(o_step),
        .i_cli(cli), .i_brk(brk), .i_rti(return_from_interrupt), .i_wait(wt), .o_cpu(cpu));

    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        check(o_rdata, exp);
    endtask

    // one-cycle pulse on the model command lines or events
    task automatic pulse(input int which, input logic [11:0] ev);
        @(posedge i_clk);
        if (which == 0) cli <= 1'b1;
        if (which == 1) brk <= 1'b1;
        if (which == 2) return_from_interrupt <= 1'b1;
        if (which == 3) i_events <= ev;
        @(posedge i_clk);
        {cli, brk, return_from_interrupt} <= 3'b000;
        i_events <= 12'h000;
    endtask

    task automatic idle(input int c);
        repeat (c) @(posedge i_clk);
        #1;
    endtask

    task automatic entry(input logic [15:0] vec);
        n = 0;
        #1;
        while (o_step.push_pc !== 1'b1 && n < 40) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        check(o_vector, vec);
        check(o_step.push_pc, 1'b1);
        check(o_irq_pending, 16'(vec != VEC_BREAK));
        idle(1);
        check({o_step.push_pc, o_step.push_p}, 2'b01);
        idle(1);
        check({o_step.set_mask, o_step.load_vec, o_step.clr_dec},
            3'b110);
    endtask

    task automatic boot(input logic [15:0] lo, input logic [15:0] hi);
        n = 0;
        while (o_step.load_vec !== 1'b1 && n < 40) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        check(o_vector, VEC_RESET);
        check({o_step.set_mask, o_step.clr_dec}, 2'b11);
        check(16'(n >= lo && n <= hi), 16'h1);
    endtask

    initial begin
        #(50 * 5000);
        err_total++;
        summarize();
    end

    initial begin
        {i_rst, i_wr, i_rd, i_ext_pin, cli, brk, return_from_interrupt, wt} = 8'h80;
        i_reset_pin = 1'b1;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        i_events = 12'h000;
        i_bank = '{bank_en: 1'b1, irq_bank: 8'h5A, prog_bank: 12'hABC};
        comparisons = 0;
        err_total = 0;
        repeat (4) @(posedge i_clk);
        #1;
        check(o_step.halt, 1'b1);
        i_rst = 1'b0;
        boot(7, 16);
        for (int a = 8'h3C; a <= 8'h40; a++) rd_chk(8'(a), 8'h00);
        $display("test reset done");
        // disabled events only set flags, even with the mask cleared
        wr(ADDR_EN_LOW, 8'h00);
        pulse(0, 12'h000);
        pulse(3, 12'h004);
        idle(4);
        check({o_irq_pending, o_step.push_pc}, 2'b00);
        rd_chk(ADDR_REQ_LOW, 8'h04);
        wr(ADDR_REQ_LOW, 8'h04);
        rd_chk(ADDR_REQ_LOW, 8'h04);
        wr(ADDR_REQ_LOW, 8'h00);
        rd_chk(ADDR_REQ_LOW, 8'h00);
        $display("test flags done");
        // wake from wait mode only for an enabled source
        wt <= 1'b1;
        wr(ADDR_EN_LOW, 8'h04);
        pulse(3, 12'h002);
        idle(4);
        check(o_wake, 1'b0);
        pulse(3, 12'h004);
        n = 0;
        #1;
        while (o_wake !== 1'b1 && n < 4) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        check(o_wake, 1'b1);
        wt <= 1'b0;
        entry(16'h7FF4);
        pulse(2, 12'h000);
        wr(ADDR_REQ_LOW, 8'h00);
        $display("test wake done");
        // all sources at once behind the mask, then priority order
        wr(ADDR_EN_LOW, 8'hFF);
        wr(ADDR_EN_HIGH, 8'hFF);
        rd_chk(ADDR_EN_LOW, 8'h7F);
        rd_chk(ADDR_EN_HIGH, 8'h0F);
        pulse(3, 12'hFFF);
        idle(5);
        check({o_irq_pending, o_step.push_pc}, 2'b00);
        rd_chk(ADDR_REQ_LOW, 8'h7F);
        rd_chk(ADDR_REQ_HIGH, 8'h0F);
        rem = FLAG_MASK;
        for (int i = 0; i < NUM_HW; i++) begin
            pulse(0, 12'h000);
            entry(EXP_VEC[i]);
            rem[PRIO_ORDER[i]] = 1'b0;
            rd_chk(ADDR_REQ_LOW, rem[7:0]);
            rd_chk(ADDR_REQ_HIGH, {4'h0, rem[11:8]});
        end
        $display("test priority done");
        // external pin rising edge
        i_ext_pin <= 1'b1;
        idle(8);
        rd_chk(ADDR_REQ_LOW, 8'h01);
        wr(ADDR_REQ_LOW, 8'h00);
        $display("test pin done");
        // break: refused under mask, then taken with bank swap
        pulse(2, 12'h000);
        idle(2);
        check(o_prog_bank, 12'hABC);
        pulse(1, 12'h000);
        idle(4);
        check(o_vector, 16'h7FEC);
        pulse(0, 12'h000);
        pulse(1, 12'h000);
        entry(16'h7FFE);
        check(o_prog_bank, 12'h05A);
        i_bank.bank_en <= 1'b0;
        idle(2);
        check(o_prog_bank, 12'hABC);
        i_bank.bank_en <= 1'b1;
        idle(2);
        check(o_prog_bank, 12'h05A);
        pulse(2, 12'h000);
        idle(2);
        check(o_prog_bank, 12'hABC);
        $display("test break done");
        // reset pin low halts, rising edge restarts
        i_reset_pin <= 1'b0;
        idle(10);
        check(o_step.halt, 1'b1);
        i_reset_pin <= 1'b1;
        boot(7, 16);
        $display("test reset pin done");
        summarize();
    end
endmodule // test_irq_ctrl

// File: verilog/irq_ctrl.sv
// Purpose: prioritized vector interrupt controller with reset sequencing
// Assumes: peripheral events are one-cycle pulses on i_clk
// Notes: cpu performs the steps that o_step announces
// How it works
// - eleven hardware sources plus break get vectors; reset has its own.
// - nothing is taken while the cpu global mask flag is set.
// - a hardware source needs its own enable bit set.
// - simultaneous requests served by fixed priority, lowest number first.
// - hardware vector pairs per source, two reserved pairs unused.
// - an enabled event wakes a waiting cpu and sets its flag.
// - flag clears by writing zero or on entry to its handler.
// - entry pushes pc, then status, sets mask, loads the vector.
// - break with mask clear enters via vector 7FFE.
// - reset pin low two cycles halts everything; held high normally.
// - rising reset pin starts six-cycle initialisation.
// - after init set mask, clear decimal, load vector 7FFC.
// - external pin edge sets the external flag.
// - dac reload pulse sets the dac flag.
// - each timer overflow sets its own timer flag.
// - port-a transition sets the port-a flag.
// - base timer overflow sets the base timer flag.
// - new display frame sets the frame flag.
// - spi buffer empty and receive ready requests, vectors 7FE8, 7FE6.
// - uart receive ready and transmit done requests; errors elsewhere.
// - request register layout across low and high byte.
// - enable register mirrors request layout at 03E and 03F.
// - in service with bank enable, program bank becomes interrupt bank.
`timescale 1ns/10ps
module irq_ctrl (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_ext_pin,
    input wire logic i_reset_pin,
    input wire logic [11:0] i_events,
    input wire irq_ctrl_pkg::cpu_in_t i_cpu,
    input wire irq_ctrl_pkg::bank_in_t i_bank,
    output irq_ctrl_pkg::step_t o_step,
    output logic [15:0] o_vector,
    output logic [11:0] o_prog_bank,
    output logic o_wake,
    output logic o_irq_pending
);
    import irq_ctrl_pkg::*;

    logic [1:0] pin_lvl;
    logic ext_q;
    logic rstpin_q;
    logic ext_rise;
    logic rst_rise;
    logic [1:0] low_cnt_q;
    logic halt_go;
    logic [11:0] set_ev;
    logic [11:0] req_q;
    logic [11:0] req_d;
    logic [11:0] en_q;
    logic [11:0] active;
    logic hit;
    logic [3:0] win;
    logic take_brk;
    logic take_hw;
    state_t state_q;
    state_t state_d;
    logic [2:0] init_cnt_q;
    logic reset_q;
    logic reset_d;
    logic svc_q;
    logic svc_d;
    logic [3:0] req_hi;

    pin_sync3 #(.W(2)) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin({i_reset_pin, i_ext_pin}),
        .o_level(pin_lvl)
    );

    // edge history of filtered pins
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ext_q <= 1'b0;
            rstpin_q <= 1'b0;
        end else begin
            ext_q <= pin_lvl[0];
            rstpin_q <= pin_lvl[1];
        end
    end

    assign ext_rise = pin_lvl[0] & ~ext_q;
    assign rst_rise = pin_lvl[1] & ~rstpin_q;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            low_cnt_q <= 2'h0;
        end else if (pin_lvl[1]) begin
            low_cnt_q <= 2'h0;
        end else if (low_cnt_q != RST_LOW_MIN) begin
            low_cnt_q <= low_cnt_q + 2'h1;
        end
    end
    assign halt_go = ~pin_lvl[1] && (low_cnt_q >= RST_LOW_MIN - 2'h1);

    // peripheral pulses map onto flag bits
    assign set_ev = (i_events | {11'h000, ext_rise}) & FLAG_MASK;

    always_comb begin
        hit = 1'b0;
        win = 4'h0;
        for (int k = NUM_HW - 1; k >= 0; k--) begin
            if (active[PRIO_ORDER[k]]) begin
                hit = 1'b1;
                win = 4'(PRIO_ORDER[k]);
            end
        end
    end

    // pending flags stay for later arbitration
    assign active = req_q & en_q & FLAG_MASK;
    assign take_brk = (state_q == S_IDLE) && !halt_go && i_cpu.brk
        && !i_cpu.mask;
    assign take_hw = (state_q == S_IDLE) && !halt_go && !i_cpu.brk
        && hit && !i_cpu.mask;

    // request flags
    always_comb begin
        req_d = req_q;
        if (i_wr && i_addr == ADDR_REQ_LOW) begin
            req_d[6:0] = req_q[6:0] & i_wdata[6:0];
        end
        if (i_wr && i_addr == ADDR_REQ_HIGH) begin
            req_d[11:8] = req_q[11:8] & i_wdata[3:0];
        end
        if (take_hw) begin
            req_d[win] = 1'b0;
        end
        req_d = req_d | set_ev;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            req_q <= REQ_RESET;
        end else begin
            req_q <= req_d;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            en_q <= EN_RESET;
        end else begin
            if (i_wr && i_addr == ADDR_EN_LOW) begin
                en_q[7:0] <= i_wdata & FLAG_MASK[7:0];
            end
            if (i_wr && i_addr == ADDR_EN_HIGH) begin
                en_q[11:8] <= i_wdata[3:0];
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                ADDR_REQ_LOW: o_rdata <= req_q[7:0] & FLAG_MASK[7:0];
                ADDR_REQ_HIGH: o_rdata <= {4'h0, req_q[11:8]};
                ADDR_EN_LOW: o_rdata <= en_q[7:0];
                ADDR_EN_HIGH: o_rdata <= {4'h0, en_q[11:8]};
                default: o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // entry sequencer
    always_comb begin
        state_d = state_q;
        reset_d = reset_q;
        case (state_q)
            S_IDLE: begin
                if (take_brk || take_hw) begin
                    state_d = S_PUSH_PC;
                    reset_d = 1'b0;
                end
            end
            S_HALT: begin
                if (rst_rise) begin
                    state_d = S_INIT;
                end
            end
            S_INIT: begin
                if (init_cnt_q == INIT_CYCLES - 3'h1) begin
                    state_d = S_VECTOR;
                    reset_d = 1'b1;
                end
            end
            S_PUSH_PC: state_d = S_PUSH_P;
            S_PUSH_P: state_d = S_VECTOR;
            S_VECTOR: state_d = S_IDLE;
            default: state_d = S_HALT;
        endcase
        if (halt_go) begin
            state_d = S_HALT;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= S_HALT;
            reset_q <= 1'b0;
        end else begin
            state_q <= state_d;
            reset_q <= reset_d;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            init_cnt_q <= 3'h0;
        end else if (state_q == S_INIT) begin
            init_cnt_q <= init_cnt_q + 3'h1;
        end else begin
            init_cnt_q <= 3'h0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_step <= '{halt: 1'b1, default: 1'b0};
        end else begin
            o_step.halt <= (state_d == S_HALT) || (state_d == S_INIT);
            o_step.push_pc <= state_d == S_PUSH_PC;
            o_step.push_p <= state_d == S_PUSH_P;
            o_step.set_mask <= state_d == S_VECTOR;
            o_step.load_vec <= state_d == S_VECTOR;
            o_step.clr_dec <= (state_d == S_VECTOR) && reset_d;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_vector <= VEC_RESET;
        end else if (take_brk) begin
            o_vector <= VEC_BREAK;
        end else if (take_hw) begin
            o_vector <= VEC_TABLE[win];
        end else if (state_q == S_INIT) begin
            o_vector <= VEC_RESET;
        end
    end

    always_comb begin
        svc_d = svc_q;
        if (i_cpu.return_from_interrupt) begin
            svc_d = 1'b0;
        end
        if (take_brk || take_hw) begin
            svc_d = 1'b1;
        end
        if (halt_go) begin
            svc_d = 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            svc_q <= 1'b0;
            o_prog_bank <= 12'h000;
        end else begin
            svc_q <= svc_d;
            // upper bits zero, lower from interrupt bank
            if (svc_d && i_bank.bank_en) begin
                o_prog_bank <= {4'h0, i_bank.irq_bank};
            end else begin
                o_prog_bank <= i_bank.prog_bank;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wake <= 1'b0;
            o_irq_pending <= 1'b0;
        end else begin
            o_wake <= i_cpu.wait_mode && |(set_ev & en_q);
            o_irq_pending <= hit && !i_cpu.mask;
        end
    end

    assign req_hi = req_q[11:8];

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    property p_take_unmasked;
        (state_q == S_IDLE && state_d == S_PUSH_PC) |-> !i_cpu.mask;
    endproperty
    a_take_unmasked: assert property (p_take_unmasked)
        else $error("entry taken with mask set");

    property p_hw_enabled;
        take_hw |-> (en_q[win] && req_q[win]);
    endproperty
    a_hw_enabled: assert property (p_hw_enabled)
        else $error("disabled source taken");

    property p_prio_top;
        (take_hw && active[BIT_SPI_TX]) |=> o_vector == 16'h7FE8;
    endproperty
    a_prio_top: assert property (p_prio_top)
        else $error("top priority source not chosen");

    property p_wake;
        (i_cpu.wait_mode && |(set_ev & en_q)) |=> o_wake;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake after enabled event");

    property p_auto_clear;
        (take_hw && !set_ev[win]) |=> !req_q[$past(win)];
    endproperty
    a_auto_clear: assert property (p_auto_clear)
        else $error("flag not cleared on entry");

    property p_entry_seq;
        @(posedge i_clk) disable iff (i_rst || !pin_lvl[1])
        (state_q == S_PUSH_PC) |-> o_step.push_pc ##1 o_step.push_p
            ##1 (o_step.set_mask && o_step.load_vec);
    endproperty
    a_entry_seq: assert property (p_entry_seq)
        else $error("entry steps out of order");

    property p_brk_vector;
        @(posedge i_clk) disable iff (i_rst || !pin_lvl[1])
        take_brk |=> ##2 (o_vector == VEC_BREAK && o_step.load_vec);
    endproperty
    a_brk_vector: assert property (p_brk_vector)
        else $error("break vector not loaded");

    property p_halt;
        halt_go |=> o_step.halt;
    endproperty
    a_halt: assert property (p_halt)
        else $error("no halt after low reset pin");

    property p_init_six;
        @(posedge i_clk) disable iff (i_rst || !pin_lvl[1])
        (state_q == S_HALT && state_d == S_INIT)
            |=> (state_q == S_INIT) [*6] ##1 (state_q == S_VECTOR);
    endproperty
    a_init_six: assert property (p_init_six)
        else $error("init not six cycles");

    property p_reset_vec;
        (state_q == S_VECTOR && reset_q) |-> (o_step.clr_dec
            && o_step.set_mask && o_vector == VEC_RESET);
    endproperty
    a_reset_vec: assert property (p_reset_vec)
        else $error("reset entry wrong");

    property p_read_high;
        (i_rd && i_addr == ADDR_REQ_HIGH) |=> o_rdata == {4'h0, $past(req_hi)};
    endproperty
    a_read_high: assert property (p_read_high)
        else $error("request high read wrong");

    property p_bank;
        (svc_q && i_bank.bank_en && !i_cpu.return_from_interrupt && !halt_go)
            |=> o_prog_bank[11:8] == 4'h0;
    endproperty
    a_bank: assert property (p_bank)
        else $error("bank not swapped in service");
endmodule // irq_ctrl

// File: verilog/irq_ctrl_pkg.sv
// Purpose: constants and types of the prioritized vector interrupt controller
// Assumes: 8-bit register port, 20 MHz system clock
// Notes: flag vectors use the request register layout, bit 7 unused
package irq_ctrl_pkg;
    // register offsets
    localparam logic [7:0] ADDR_REQ_LOW = 8'h3C;
    localparam logic [7:0] ADDR_REQ_HIGH = 8'h3D;
    localparam logic [7:0] ADDR_EN_LOW = 8'h3E;
    localparam logic [7:0] ADDR_EN_HIGH = 8'h3F;
    localparam logic [11:0] REQ_RESET = 12'h000;
    localparam logic [11:0] EN_RESET = 12'h000;
    localparam logic [11:0] FLAG_MASK = 12'hF7F;
    // flag bit positions
    localparam int BIT_EXT = 0;
    localparam int BIT_DAC = 1;
    localparam int BIT_T0 = 2;
    localparam int BIT_T1 = 3;
    localparam int BIT_PORTA = 4;
    localparam int BIT_BASE = 5;
    localparam int BIT_FRAME = 6;
    localparam int BIT_SPI_TX = 8;
    localparam int BIT_SPI_RX = 9;
    localparam int BIT_UART_TX = 10;
    localparam int BIT_UART_RX = 11;
    localparam int NUM_HW = 11;
    // flag bits from priority 2 down to priority 12
    localparam int PRIO_ORDER [0:10] = '{BIT_SPI_TX, BIT_SPI_RX,
        BIT_UART_TX, BIT_UART_RX, BIT_EXT, BIT_DAC, BIT_T0, BIT_T1,
        BIT_PORTA, BIT_BASE, BIT_FRAME};
    // low-byte vector address per flag bit
    localparam logic [15:0] VEC_TABLE [0:11] = '{16'h7FF8, 16'h7FF6,
        16'h7FF4, 16'h7FF2, 16'h7FF0, 16'h7FEE, 16'h7FEC, 16'h0000,
        16'h7FE8, 16'h7FE6, 16'h7FE4, 16'h7FE2};
    localparam logic [15:0] VEC_RESET = 16'h7FFC;
    localparam logic [15:0] VEC_BREAK = 16'h7FFE;
    // timing counts in clock cycles
    localparam logic [2:0] INIT_CYCLES = 3'h6;
    localparam logic [1:0] RST_LOW_MIN = 2'h2;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_HALT = 3'b001,
        S_INIT = 3'b010,
        S_PUSH_PC = 3'b011,
        S_PUSH_P = 3'b100,
        S_VECTOR = 3'b101
    } state_t;

    typedef struct packed {
        logic mask;
        logic brk;
        logic return_from_interrupt;
        logic wait_mode;
    } cpu_in_t;

    typedef struct packed {
        logic bank_en;
        logic [7:0] irq_bank;
        logic [11:0] prog_bank;
    } bank_in_t;

    typedef struct packed {
        logic halt;
        logic push_pc;
        logic push_p;
        logic set_mask;
        logic clr_dec;
        logic load_vec;
    } step_t;
endpackage

// File: verilog/pin_sync3.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: pins asynchronous to i_clk
// Notes: level changes only when stages two and three agree
`timescale 1ns/10ps
module pin_sync3 #(
    parameter int W = 2
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_pin,
    output logic [W-1:0] o_level
);
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    o_level[g] <= 1'b0;
                end else begin
                    s1_q <= i_pin[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        o_level[g] <= s3_q;
                    end
                end
            end
        end
    endgenerate
endmodule // pin_sync3
